// ---- shared/rle_pkg.sv ----
// rle_pkg: constants, register map and carrier types of the location engine loader.
// assumes a 50 MHz system clock and a 32-bit apb register port.
package rle_pkg;
  // clock rate and estimate time limit
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned EST_MAX_US = 13000;
  localparam int unsigned EST_MAX_CYC = EST_MAX_US * CLK_MHZ;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_COORD = 8'h04;
  localparam logic [7:0] ADDR_PARAM = 8'h08;
  localparam logic [7:0] ADDR_X = 8'h0c;
  localparam logic [7:0] ADDR_Y = 8'h10;
  localparam logic [7:0] ADDR_IDX = 8'h14;

  // engine_ctrl_stat bit positions
  localparam int unsigned EN_BIT = 0;
  localparam int unsigned COORD_LD_BIT = 1;
  localparam int unsigned PARAM_LD_BIT = 2;
  localparam int unsigned START_BIT = 3;
  localparam int unsigned DONE_BIT = 4;
  localparam int unsigned BUSY_BIT = 5;

  // load layout
  localparam int unsigned NUM_SLOTS = 16;
  localparam logic [5:0] NUM_COORD = 6'h20;
  localparam logic [5:0] NUM_PARAM = 6'h16;
  localparam int unsigned PARAM_A = 0;
  localparam int unsigned PARAM_N = 1;
  localparam int unsigned PARAM_XMIN = 2;
  localparam int unsigned PARAM_XDELTA = 3;
  localparam int unsigned PARAM_RSSI0 = 6;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam logic [7:0] WEIGHT_MAX = 8'hff;

  // one queued port write
  typedef struct packed {
    logic is_param;
    logic [4:0] slot;
    logic [7:0] data;
  } rle_load_t;

  // control bits held by software
  typedef struct packed {
    logic param_ld;
    logic coord_ld;
    logic en;
  } rle_ctrl_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACC = 2'b01,
    ST_DIV = 2'b11,
    ST_FIN = 2'b10
  } rle_state_t;
endpackage

// ---- verification/rle_cpu.sv ----
// rle_cpu: apb master model of the controlling processor.
// assumes a registered pready and the engine's clock.
`timescale 1ns/10ps
module rle_cpu import rle_pkg::*; (
  input wire logic clock,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  int hung = 0;
  logic rerr;
  logic [31:0] rdata;
  // bus idle at time zero
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // one transfer; a released bus shows inverted address and write data, not stale ones
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // hold the request until pready is seen high at a rising edge or 500 edges pass, then let go
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 500);
    if (pready !== 1'b1) hung++;
    rdata = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  // framed load: enable with flag up, bytes in order, then flag down
  task automatic load(input int f, input logic [7:0] b [32], input int cnt);
    logic [7:0] a;
    a = f == COORD_LD_BIT ? ADDR_COORD : ADDR_PARAM;
    xfer(1'b1, ADDR_CTRL, 32'h1 | 32'h1 << f);
    for (int i = 0; i < cnt; i++) xfer(1'b1, a, {24'h0, b[i]});
    xfer(1'b1, ADDR_CTRL, 32'h1);
  endtask
endmodule

// ---- verification/rle_engine_monitor.sv ----
// rle_engine_monitor: apb timing and map checks at the engine ports.
// assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
module rle_engine_monitor import rle_pkg::*; (
  input wire logic clock,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic rd, bad;
  // unaligned or past the index register counts as a hole
  assign rd = pready && !pwrite;
  assign bad = paddr > ADDR_IDX || paddr[1:0] != 2'h0;
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held");
  read_wait_a: assert property ($rose(penable) && !pwrite |-> !pready ##1 pready)
    else $error("read wait wrong");
  error_map_a: assert property (pready |-> pslverr == bad)
    else $error("error flag wrong");
  zero_reads_a: assert property (rd && (bad || paddr == ADDR_COORD) |-> prdata == 32'h0)
    else $error("read not zero");
  start_reads_a: assert property (rd && paddr == ADDR_CTRL |-> !prdata[START_BIT])
    else $error("start reads one");
  index_bound_a: assert property (rd && paddr == ADDR_IDX |->
    prdata[5:0] <= NUM_COORD && prdata[11:6] <= NUM_PARAM)
    else $error("index too far");
  reset_quiet_a: assert property ($rose(rstn) |-> !pready && prdata == 32'h0)
    else $error("reset not quiet");
endmodule
bind rle_engine rle_engine_monitor rle_engine_monitor_inst (.clock, .rstn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

// ---- verification/rle_engine_test.sv ----
// rle_engine_test: self-checking bench for the engine loader.
// assumes rle_cpu drives apb; the monitor binds itself in.
`timescale 1ns/10ps
module rle_engine_test import rle_pkg::*; ();
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [7:0] cx [32];
  logic [7:0] pv [32];
  logic [31:0] pwdata, prdata;
  logic [31:0] seed = 32'h8a8c387c;
  int num_errors = 0;
  int comparisons = 0;
  int k;
  rle_cpu rle_cpu_inst (.clock, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);
  rle_engine #(.EST_LIMIT_CYC(64)) rle_engine_inst (.clock, .rstn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr);
  // 50 MHz clock
  initial forever #10 clock = ~clock;
  // xorshift source, fixed seed
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected centroid on one axis, clamped to the search box
  function automatic logic [7:0] cent(input int ax);
    int w, r;
    int sw = 0;
    int s = 0;
    int lo = pv[2+2*ax];
    int hi = lo + pv[3+2*ax];
    for (int i = 0; i < 16; i++) begin
      w = pv[6+i] == 0 ? 0 : pv[6+i] < pv[0] ? 255 : 255 - pv[6+i] + pv[0];
      sw += w;
      s += w * cx[2*i+ax];
    end
    r = sw == 0 ? lo : s / sw;
    return 8'(r < lo ? lo : r > hi ? hi : r);
  endfunction
  task automatic check(input string nm, input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic summarize();
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // read a register and compare it
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    rle_cpu_inst.xfer(1'b0, a, 32'h0);
    check(nm, rle_cpu_inst.rdata, e);
  endtask
  // start an estimate and poll done within a bound; a miss ends the run
  task automatic run();
    rle_cpu_inst.xfer(1'b1, ADDR_CTRL, 32'h9);
    k = 0;
    do begin
      rle_cpu_inst.xfer(1'b0, ADDR_CTRL, 32'h0);
      k++;
    end while (rle_cpu_inst.rdata[DONE_BIT] !== 1'b1 && k < 99);
    check("done", {31'h0, rle_cpu_inst.rdata[DONE_BIT]}, 32'h1);
    if (rle_cpu_inst.rdata[DONE_BIT] !== 1'b1) summarize();
  endtask
  // a bus wait that ran out its bound is a mismatch and ends the run
  initial begin
    wait (rle_cpu_inst.hung != 0);
    check("hung", rle_cpu_inst.hung, 32'h0);
    summarize();
  end
  initial begin
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    rdc("ctrl", ADDR_CTRL, 32'h0);
    rdc("hole", 8'h18, 32'h0);
    check("err", {31'h0, rle_cpu_inst.rerr}, 32'h1);
    // port write while disabled is dropped
    rle_cpu_inst.xfer(1'b1, ADDR_COORD, 32'h5);
    rdc("idx", ADDR_IDX, 32'h0);
    for (int r = 0; r < 2; r++) begin
      // twelve live slots, zeroed tail; the second run has none live
      for (int i = 0; i < 32; i++) begin
        cx[i] = i < 24 ? 8'(rnd()) : 8'h0;
        pv[i] = 8'(i < 6 ? 32'h40 + rnd() % 64 : i < 18 && r == 0 ? 32'h50 + rnd() % 112 : 0);
      end
      rle_cpu_inst.load(COORD_LD_BIT, cx, 32);
      rle_cpu_inst.xfer(1'b1, ADDR_COORD, 32'h7);
      rdc("cidx", ADDR_IDX, {20'h0, r ? NUM_PARAM : 6'h0, NUM_COORD});
      rle_cpu_inst.load(PARAM_LD_BIT, pv, 22);
      rdc("pidx", ADDR_IDX, {20'h0, NUM_PARAM, NUM_COORD});
      run();
      rdc("x", ADDR_X, {24'h0, cent(0)});
      rdc("y", ADDR_Y, {24'h0, cent(1)});
    end
    // start with enable clear is ignored; done and results stay put
    rle_cpu_inst.xfer(1'b1, ADDR_CTRL, 32'h8);
    rdc("ctrl", ADDR_CTRL, 32'h10);
    rdc("xhold", ADDR_X, {24'h0, cent(0)});
    // start and reopen the coordinate load at once: writes made while the
    // estimate runs queue in the load buffer and must land in order later
    rle_cpu_inst.xfer(1'b1, ADDR_CTRL, 32'hb);
    rdc("busy", ADDR_CTRL, 32'h23);
    for (int i = 0; i < 32; i++) begin
      cx[i] = 8'(rnd());
      pv[i] = 8'(i < 6 ? 32'h40 + rnd() % 64 : i < 22 ? 32'h50 + rnd() % 112 : 0);
    end
    rle_cpu_inst.load(COORD_LD_BIT, cx, 32);
    rdc("qidx", ADDR_IDX, {20'h0, NUM_PARAM, NUM_COORD});
    rle_cpu_inst.load(PARAM_LD_BIT, pv, 22);
    run();
    rdc("qx", ADDR_X, {24'h0, cent(0)});
    rdc("qy", ADDR_Y, {24'h0, cent(1)});
    // reset after the last run clears the results
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    rdc("x", ADDR_X, 32'h0);
    check("hang", rle_cpu_inst.hung, 32'h0);
    summarize();
  end
endmodule

// ---- verilog/rle_engine.sv ----
// rle_engine: apb-attached location engine with load fifo and estimator.
// assumes apb signals synchronous to clock and a single 50 MHz clock domain.
//
// Contract
// - disable stops engine clocking, no activity
// - estimate one pair from sixteen slots
// - coordinates unsigned six.two fixed point
// - zero signal strength marks slot unused
// - coordinates interleave x then y per slot
// - estimate finishes within thirteen milliseconds
// - start bit runs, done marks valid results
// - no interrupt, completion seen by polling
// - results held until next finish or reset
`timescale 1ns/10ps

module rle_fifo #(
  parameter int unsigned WIDTH = 14,
  parameter int unsigned DEPTH = 32
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage needs no reset, only the pointers and the count do
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module rle_engine import rle_pkg::*; #(
  parameter int unsigned EST_LIMIT_CYC = EST_MAX_CYC
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  rle_ctrl_t ctrl_r;
  rle_state_t state_r;
  logic done_r;
  logic start_pend_r;
  logic [5:0] coord_idx_r;
  logic [5:0] param_idx_r;
  logic [7:0] coord_mem [32];
  logic [7:0] param_mem [22];
  logic [7:0] res_r [2];
  logic [3:0] slot_r;
  logic [2:0] div_bit_r;
  logic [19:0] busy_cnt_r;
  logic eng_ce;
  logic access;
  logic wr_ok;
  logic rd_ok;
  logic mapped;
  logic port_wr;
  logic push_ok;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  rle_load_t push_ent;
  rle_load_t pop_ent;
  logic [7:0] rssi;
  logic [7:0] over_a;
  logic [7:0] weight;
  logic [11:0] sum_w_r;
  rle_ctrl_t ctrl_wr;
  logic timeout;

  // clock gating is modelled as an enable: nothing in the engine moves while off
  assign eng_ce = ctrl_r.en;
  assign access = psel && penable;
  assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_COORD) || (paddr == ADDR_PARAM) ||
                  (paddr == ADDR_X) || (paddr == ADDR_Y) || (paddr == ADDR_IDX);
  assign wr_ok = access && pready && pwrite && mapped;
  assign rd_ok = access && !pwrite;
  assign port_wr = pwrite && ((paddr == ADDR_COORD) || (paddr == ADDR_PARAM));
  assign ctrl_wr = rle_ctrl_t'({pwdata[PARAM_LD_BIT], pwdata[COORD_LD_BIT], pwdata[EN_BIT]});
  assign timeout = (busy_cnt_r >= 20'(EST_LIMIT_CYC - 1));

  // a port write is queued only with engine on, flag set and slot in range
  always_comb begin
    push_ok = 1'b0;
    push_ent = '0;
    push_ent.data = pwdata[7:0];
    if (wr_ok && ctrl_r.en && (paddr == ADDR_COORD) && ctrl_r.coord_ld &&
        (coord_idx_r < NUM_COORD)) begin
      push_ok = 1'b1;
      push_ent.slot = coord_idx_r[4:0];
    end else if (wr_ok && ctrl_r.en && (paddr == ADDR_PARAM) && ctrl_r.param_ld &&
                 (param_idx_r < NUM_PARAM)) begin
      push_ok = 1'b1;
      push_ent.is_param = 1'b1;
      push_ent.slot = param_idx_r[4:0];
    end
  end

  rle_fifo #(
    .WIDTH($bits(rle_load_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rstn(rstn),
    .in_valid(push_ok),
    .in_ready(fifo_in_ready),
    .in_data(push_ent),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(pop_ent)
  );

  // apb answer: one wait state, longer while a port write meets a full fifo
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= access && !pready && !(port_wr && !fifo_in_ready);
      pslverr <= access && !pready && !(port_wr && !fifo_in_ready) && !mapped;
    end
  end

  // read data, captured the cycle before the completing edge
  always_ff @(posedge clock) begin
    if (!rstn) begin
      prdata <= '0;
    end else if (rd_ok && !pready) begin
      prdata <= '0;
      case (paddr)
        ADDR_CTRL: begin
          prdata[EN_BIT] <= ctrl_r.en;
          prdata[COORD_LD_BIT] <= ctrl_r.coord_ld;
          prdata[PARAM_LD_BIT] <= ctrl_r.param_ld;
          prdata[DONE_BIT] <= done_r;
          prdata[BUSY_BIT] <= (state_r != ST_IDLE) || start_pend_r;
        end
        ADDR_X: prdata[7:0] <= res_r[0];
        ADDR_Y: prdata[7:0] <= res_r[1];
        ADDR_IDX: prdata[13:0] <= {2'b00, param_idx_r, coord_idx_r};
        default: prdata <= '0;
      endcase
    end
  end

  // control bits and write indices; a flag rise rewinds its index
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctrl_r <= '0;
      coord_idx_r <= '0;
      param_idx_r <= '0;
    end else if (wr_ok && (paddr == ADDR_CTRL)) begin
      ctrl_r <= ctrl_wr;
      if (ctrl_wr.coord_ld && !ctrl_r.coord_ld) begin
        coord_idx_r <= '0;
      end
      if (ctrl_wr.param_ld && !ctrl_r.param_ld) begin
        param_idx_r <= '0;
      end
    end else if (push_ok && !push_ent.is_param) begin
      coord_idx_r <= coord_idx_r + 6'h01;
    end else if (push_ok) begin
      param_idx_r <= param_idx_r + 6'h01;
    end
  end

  // drain the queue only while idle, so a running estimate stalls the loader
  assign fifo_pop = eng_ce && (state_r == ST_IDLE) && fifo_out_valid;

  always_ff @(posedge clock) begin
    if (fifo_pop && !pop_ent.is_param) begin
      coord_mem[pop_ent.slot] <= pop_ent.data;
    end
    if (fifo_pop && pop_ent.is_param) begin
      param_mem[pop_ent.slot] <= pop_ent.data;
    end
  end

  // per-slot weight: full weight for rssi below PARAM_A, smaller as rssi rises above it, zero rssi none
  assign rssi = param_mem[PARAM_RSSI0 + 32'(slot_r)];
  assign over_a = rssi - param_mem[PARAM_A];
  always_comb begin
    if (rssi == 8'h00) begin
      weight = 8'h00;
    end else if (rssi >= param_mem[PARAM_A]) begin
      weight = WEIGHT_MAX - over_a;
    end else begin
      weight = WEIGHT_MAX;
    end
  end

  // start request and done flag; finish sets done even against a new start
  always_ff @(posedge clock) begin
    if (!rstn) begin
      start_pend_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      if (wr_ok && (paddr == ADDR_CTRL) && pwdata[START_BIT] && ctrl_wr.en) begin
        start_pend_r <= 1'b1;
        done_r <= 1'b0;
      end else if (eng_ce && (state_r == ST_IDLE) && !fifo_out_valid) begin
        start_pend_r <= 1'b0;
      end
      if (eng_ce && (state_r == ST_FIN)) begin
        done_r <= 1'b1;
      end
    end
  end

  // sequencer: accumulate sixteen slots, then an eight-step divide
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      slot_r <= '0;
      div_bit_r <= '0;
      sum_w_r <= '0;
      busy_cnt_r <= '0;
    end else if (eng_ce) begin
      busy_cnt_r <= (state_r == ST_IDLE) ? '0 : busy_cnt_r + 20'h00001;
      case (state_r)
        ST_IDLE: begin
          // wait until every queued load has landed before computing
          if (start_pend_r && !fifo_out_valid) begin
            state_r <= ST_ACC;
            slot_r <= '0;
            sum_w_r <= '0;
          end
        end
        ST_ACC: begin
          sum_w_r <= sum_w_r + 12'(weight);
          slot_r <= slot_r + 4'h1;
          if (slot_r == 4'(NUM_SLOTS - 1)) begin
            state_r <= ST_DIV;
            div_bit_r <= 3'h7;
          end
        end
        ST_DIV: begin
          div_bit_r <= div_bit_r - 3'h1;
          if ((div_bit_r == 3'h0) || timeout) begin
            state_r <= ST_FIN;
          end
        end
        ST_FIN: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // one accumulator, divider and clamp per axis
  for (genvar g = 0; g < 2; g++) begin : g_axis
    logic [19:0] sum_r;
    logic [19:0] rem_r;
    logic [7:0] quo_r;
    logic [19:0] trial;
    logic [7:0] lo;
    logic [8:0] hi;

    assign trial = 20'(sum_w_r) << div_bit_r;
    assign lo = param_mem[PARAM_XMIN + 2 * g];
    assign hi = 9'(lo) + 9'(param_mem[PARAM_XDELTA + 2 * g]);

    always_ff @(posedge clock) begin
      if (!rstn) begin
        sum_r <= '0;
        rem_r <= '0;
        quo_r <= '0;
      end else if (eng_ce) begin
        if (state_r == ST_IDLE) begin
          sum_r <= '0;
        end else if (state_r == ST_ACC) begin
          sum_r <= sum_r + 20'(weight) * 20'(coord_mem[2 * slot_r + g]);
          if (slot_r == 4'(NUM_SLOTS - 1)) begin
            rem_r <= sum_r + 20'(weight) * 20'(coord_mem[2 * slot_r + g]);
            quo_r <= '0;
          end
        end else if ((state_r == ST_DIV) && (rem_r >= trial)) begin
          rem_r <= rem_r - trial;
          quo_r[div_bit_r] <= 1'b1;
        end
      end
    end

    // results change only at finish or reset, held otherwise
    always_ff @(posedge clock) begin
      if (!rstn) begin
        res_r[g] <= '0;
      end else if (eng_ce && (state_r == ST_FIN)) begin
        if ((sum_w_r == '0) || (quo_r < lo)) begin
          res_r[g] <= lo;
        end else if (9'(quo_r) > hi) begin
          res_r[g] <= hi[7:0];
        end else begin
          res_r[g] <= quo_r;
        end
      end
    end
  end
endmodule
